// [logic/uhr_pkg.sv]
// constants for the host controller miscellaneous and buffer control registers
package uhr_pkg;
   // ********************************************************************
   // command codes
   // ********************************************************************
   localparam logic [7:0] CMD_ID_RD      = 8'h27;
   localparam logic [7:0] CMD_SCRATCH_RD = 8'h28;
   localparam logic [7:0] CMD_SCRATCH_WR = 8'hA8;
   localparam logic [7:0] CMD_SWRST_WR   = 8'hA9;
   localparam logic [7:0] CMD_ISOLEN_RD  = 8'h2A;
   localparam logic [7:0] CMD_ISOLEN_WR  = 8'hAA;
   localparam logic [7:0] CMD_ACKLEN_RD  = 8'h2B;
   localparam logic [7:0] CMD_ACKLEN_WR  = 8'hAB;
   localparam logic [7:0] CMD_STATUS_RD  = 8'h2C;
   localparam logic [7:0] CMD_ISOPORT_RD = 8'h40;
   localparam logic [7:0] CMD_ISOPORT_WR = 8'hC0;
   localparam logic [7:0] CMD_ACKPORT_RD = 8'h41;
   localparam logic [7:0] CMD_ACKPORT_WR = 8'hC1;
   // ********************************************************************
   // values and field positions
   // ********************************************************************
   localparam logic [15:0] SWRST_VALUE   = 16'h00F6;
   localparam logic [15:0] WORD_RESET    = 16'h0000;
   localparam logic [15:0] PTR_STEP      = 16'h0002;
   localparam logic [15:0] TOTAL_RAM     = 16'h1000;
   localparam int          ST_ISO0_FULL  = 0;
   localparam int          ST_ISO1_FULL  = 1;
   localparam int          ST_ACK_FULL   = 2;
   localparam int          ST_ISO0_DONE  = 3;
   localparam int          ST_ISO1_DONE  = 4;
   localparam int          ST_ACK_DONE   = 5;
   localparam int          ST_USED       = 6;
   // ********************************************************************
   // data port state
   // ********************************************************************
   typedef enum logic [1:0] {UHR_IDLE, UHR_ISO, UHR_ACK} uhr_port_t;
endpackage : uhr_pkg

// [logic/uhr_regs.sv]
// miscellaneous and buffer-ram control registers of the embedded usb host controller
//
// Contract
// [RL1] read code 27 returns the read-only id word, product in the upper byte, revision below.
// [RL2] a 16-bit scratch word resets to zero, is written by code A8 and read back by code 28.
// [RL3] writing F6H with code A9 returns every register to default but leaves buffer ram alone.
// [RL4] a 16-bit isochronous length, written AA and read 2A, sizes both isochronous buffers.
// [RL5] a 16-bit acknowledged length, written AB and read 2B, resets to zero.
// [RL6] software keeps acknowledged length plus twice the isochronous length within 1000H.
// [RL7] status bits 5, 4, 3 flag acknowledged, iso 1 and iso 0 buffers read by the controller.
// [RL8] status bits 2, 1, 0 flag acknowledged, iso 1 and iso 0 buffers full.
// [RL9] software loads the transfer count and checks status before using a data port.
// [RL10] each data-port word moves the pointer by two until the count, then ends the transfer.
// [RL11] a software-reset write with any other value changes nothing.
// [RL12] status bits 15 to 6 read zero and all flags are zero after reset.
`timescale 1ns/10ps
module uhr_regs #(
   parameter logic [15:0] ID_WORD = 16'h5A01  // arbitrary value
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        cmd_valid,
   input  wire logic [7:0]  cmd_code,
   input  wire logic        wr_valid,
   input  wire logic [15:0] wr_data,
   input  wire logic        rd_strobe,
   output logic      [15:0] rd_data,
   input  wire logic [15:0] transfer_byte_counter,
   input  wire logic [2:0]  buffer_done_set,
   input  wire logic [2:0]  buffer_done_clr,
   input  wire logic [2:0]  buffer_read_set,
   input  wire logic [2:0]  buffer_read_clr,
   output logic      [15:0] isochronous_length_field,
   output logic      [15:0] acknowledged_length_field,
   output logic      [15:0] buffer_pointer,
   output logic             port_access,
   output logic             end_of_transfer,
   output logic             soft_reset_pulse,
   output logic             length_overflow
);
   // ********************************************************************
   // state
   // ********************************************************************
   typedef struct packed {
      logic [7:0]         cmd;
      uhr_pkg::uhr_port_t port;
      logic [15:0]        scratch_word;
      logic [15:0]        iso_len;
      logic [15:0]        ack_len;
      logic [15:0]        ptr;
      logic [2:0]         full;
      logic [2:0]         done;
      logic [15:0]        rdata;
      logic               eot;
      logic               srst;
   } uhr_state_t;

   uhr_state_t st;
   uhr_state_t next_st;
   logic       access;
   logic       write_now;
   logic [17:0] total_len;

   assign access    = ce && (rd_strobe || wr_valid) && (st.port != uhr_pkg::UHR_IDLE);
   assign write_now = ce && wr_valid;
   // total is 18 bits: ack length plus twice a full-scale iso length needs them all
   assign total_len = {2'b00, st.ack_len} + {1'b0, st.iso_len, 1'b0};

   // ********************************************************************
   // next state
   // ********************************************************************
   always_comb begin
      next_st      = st;
      next_st.eot  = 1'b0;
      next_st.srst = 1'b0;
      if (cmd_valid) begin
         next_st.cmd = cmd_code;
         case (cmd_code)
            uhr_pkg::CMD_ISOPORT_RD, uhr_pkg::CMD_ISOPORT_WR: begin
               next_st.port = uhr_pkg::UHR_ISO;
               next_st.ptr  = uhr_pkg::WORD_RESET;
            end
            uhr_pkg::CMD_ACKPORT_RD, uhr_pkg::CMD_ACKPORT_WR: begin
               next_st.port = uhr_pkg::UHR_ACK;
               next_st.ptr  = uhr_pkg::WORD_RESET;
            end
            default: next_st.port = uhr_pkg::UHR_IDLE;
         endcase
         case (cmd_code)
            uhr_pkg::CMD_ID_RD:      next_st.rdata = ID_WORD;                            // [RL1]
            uhr_pkg::CMD_SCRATCH_RD: next_st.rdata = st.scratch_word;                    // [RL2]
            uhr_pkg::CMD_ISOLEN_RD:  next_st.rdata = st.iso_len;                         // [RL4]
            uhr_pkg::CMD_ACKLEN_RD:  next_st.rdata = st.ack_len;                         // [RL5]
            uhr_pkg::CMD_STATUS_RD:  next_st.rdata = {10'h000, st.done, st.full};        // [RL7] [RL8] [RL12]
            default:                 next_st.rdata = uhr_pkg::WORD_RESET;
         endcase
      end else if (write_now) begin
         case (st.cmd)
            uhr_pkg::CMD_SCRATCH_WR: next_st.scratch_word = wr_data;                     // [RL2]
            uhr_pkg::CMD_ISOLEN_WR:  next_st.iso_len      = wr_data;                     // [RL4]
            uhr_pkg::CMD_ACKLEN_WR:  next_st.ack_len      = wr_data;                     // [RL5]
            uhr_pkg::CMD_SWRST_WR:   next_st.srst = (wr_data == uhr_pkg::SWRST_VALUE);   // [RL3] [RL11]
            default: ;
         endcase
      end
      // data port: pointer walks in words, end fires once the count is reached
      if (!cmd_valid && access && st.ptr < transfer_byte_counter) begin
         next_st.ptr = st.ptr + uhr_pkg::PTR_STEP;                                       // [RL10]
         if (st.ptr + uhr_pkg::PTR_STEP >= transfer_byte_counter) begin
            next_st.eot  = 1'b1;                                                         // [RL10]
            next_st.port = uhr_pkg::UHR_IDLE;
         end
      end
      // set wins over clear for each flag
      next_st.full = (st.full & ~buffer_read_clr) | buffer_read_set;                     // [RL8]
      next_st.done = (st.done & ~buffer_done_clr) | buffer_done_set;                     // [RL7]
      if (st.srst) begin
         next_st = '0;                                                                   // [RL3]
      end
   end

   // ********************************************************************
   // registers
   // ********************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;                                                                       // [RL12]
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign rd_data                   = st.rdata;
   assign isochronous_length_field  = st.iso_len;
   assign acknowledged_length_field = st.ack_len;
   assign buffer_pointer            = st.ptr;
   assign port_access               = access;
   assign end_of_transfer           = st.eot;
   assign soft_reset_pulse          = st.srst;
   // flag only: the device does not enforce the partition limit
   assign length_overflow           = total_len > {2'b00, uhr_pkg::TOTAL_RAM};            // [RL6]
endmodule : uhr_regs

// [testbench/uhr_regs_properties.sv]
// port checker for the uhr_regs register bank
`timescale 1ns/10ps
module uhr_regs_properties #(
   parameter logic [15:0] ID_WORD = 16'h0000
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic        cmd_valid,
   input wire logic [7:0]  cmd_code,
   input wire logic        wr_valid,
   input wire logic [15:0] wr_data,
   input wire logic [15:0] rd_data,
   input wire logic [15:0] transfer_byte_counter,
   input wire logic [15:0] isochronous_length_field,
   input wire logic [15:0] acknowledged_length_field,
   input wire logic [15:0] buffer_pointer,
   input wire logic        port_access,
   input wire logic        end_of_transfer,
   input wire logic        soft_reset_pulse
);
   // writes land in the register of the last command taken
   logic [7:0] last_cmd;
   always_ff @(posedge clk) begin
      if (rst)
         last_cmd <= 8'h00;
      // a soft reset also forgets the command taken before it
      else if (ce && soft_reset_pulse)
         last_cmd <= 8'h00;
      else if (ce && cmd_valid)
         last_cmd <= cmd_code;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_cmd(c); ce && cmd_valid && cmd_code == c; endsequence
   sequence s_wr(c); ce && !cmd_valid && wr_valid && last_cmd == c; endsequence
   chk_id_value: assert property (s_cmd(8'h27) |=> rd_data == ID_WORD)
      else $error("id word wrong");
   chk_iso_write: assert property (s_wr(8'hAA) |=> isochronous_length_field == $past(wr_data))
      else $error("iso length not written");
   chk_ack_write: assert property (s_wr(8'hAB) |=> acknowledged_length_field == $past(wr_data))
      else $error("ack length not written");
   chk_swrst_clear: assert property (s_wr(8'hA9) ##0 wr_data == 16'h00F6 |=> soft_reset_pulse
      ##1 isochronous_length_field == 16'h0000 && acknowledged_length_field == 16'h0000)
      else $error("soft reset missing");
   chk_swrst_other: assert property (s_wr(8'hA9) ##0 wr_data != 16'h00F6
      |=> !soft_reset_pulse && $stable(acknowledged_length_field))
      else $error("soft reset on wrong value");
   chk_status_zero: assert property (s_cmd(8'h2C) |=> rd_data[15:6] == 10'h000)
      else $error("status reserved bits set");
   chk_ptr_step: assert property (ce && port_access && !cmd_valid
      && buffer_pointer + 16'h0002 < transfer_byte_counter
      |=> buffer_pointer == $past(buffer_pointer) + 16'h0002)
      else $error("pointer step wrong");
   chk_eot_raise: assert property (ce && port_access && !cmd_valid
      && buffer_pointer < transfer_byte_counter
      && buffer_pointer + 16'h0002 >= transfer_byte_counter
      |=> end_of_transfer ##1 !end_of_transfer)
      else $error("end of transfer wrong");
endmodule : uhr_regs_properties
bind uhr_regs uhr_regs_properties #(.ID_WORD(ID_WORD)) chk_u (
   .clk, .rst, .ce, .cmd_valid, .cmd_code, .wr_valid, .wr_data, .rd_data,
   .transfer_byte_counter, .isochronous_length_field, .acknowledged_length_field,
   .buffer_pointer, .port_access, .end_of_transfer, .soft_reset_pulse);

// [testbench/uhr_host_model.sv]
// host processor model driving the command interface
`timescale 1ns/10ps
module uhr_host_model (
   input  wire logic        clk,
   input  wire logic [15:0] rd_data,
   output logic             cmd_valid,
   output logic      [7:0]  cmd_code,
   output logic             wr_valid,
   output logic      [15:0] wr_data,
   output logic             rd_strobe
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code  = 8'h00;
      wr_valid  = 1'b0;
      wr_data   = 16'h0000;
      rd_strobe = 1'b0;
   end
   task automatic cmd(input logic [7:0] c);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_code  = c;
      @(negedge clk);
      cmd_valid = 1'b0;
   endtask : cmd
   // callers keep ack length plus twice the iso length within 1000H
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      cmd(c);
      wr_valid = 1'b1;
      wr_data  = d;
      @(negedge clk);
      wr_valid = 1'b0;
      wr_data  = ~d;  // released data shows no stale word
   endtask : wr
   task automatic rd(input logic [7:0] c, output logic [15:0] d);
      cmd(c);
      d = rd_data;
   endtask : rd
   task automatic strobe();
      @(negedge clk);
      rd_strobe = 1'b1;
      @(negedge clk);
      rd_strobe = 1'b0;
   endtask : strobe
endmodule : uhr_host_model

// [testbench/uhr_regs_bench.sv]
// self-checking bench for the uhr_regs register bank
`timescale 1ns/10ps
module uhr_regs_bench;
   localparam logic [15:0] ID = 16'h6C03;  // arbitrary value
   logic        clk, rst, ce, cmd_valid, wr_valid, rd_strobe, end_of_transfer, overflow;
   logic [7:0]  cmd_code;
   logic [15:0] wr_data, rd_data, transfer_byte_counter;
   logic [15:0] eots = 16'h0000;
   logic [2:0]  done_set, read_set, done_clr, read_clr;
   logic [7:0]  codes [4] = '{8'h28, 8'h2A, 8'h2B, 8'h2C};
   int          fails = 0;
   int          comparisons = 0;
   uhr_regs #(.ID_WORD(ID)) dut_u (.clk, .rst, .ce, .cmd_valid, .cmd_code,
      .wr_valid, .wr_data, .rd_strobe, .rd_data, .transfer_byte_counter,
      .buffer_done_set(done_set), .buffer_done_clr(done_clr), .buffer_read_set(read_set),
      .buffer_read_clr(read_clr), .isochronous_length_field(), .acknowledged_length_field(),
      .buffer_pointer(), .port_access(), .end_of_transfer, .soft_reset_pulse(),
      .length_overflow(overflow));
   uhr_host_model host_u (.clk, .rd_data, .cmd_valid, .cmd_code, .wr_valid, .wr_data,
      .rd_strobe);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) if (end_of_transfer === 1'b1) eots = eots + 16'h0001;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] c, input logic [15:0] exp);
      logic [15:0] d;
      host_u.rd(c, d);
      chk(d, exp);
   endtask : rdc
   task automatic wrap_up();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up
   // a hang counts as a mismatch
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      wrap_up();
   end
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      transfer_byte_counter = 16'h0006;
      done_set = 3'h0;
      read_set = 3'h0;
      done_clr = 3'h0;
      read_clr = 3'h0;
      repeat (20) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      rdc(8'h27, ID);
      rdc(8'h2C, 16'h0000);
      host_u.wr(8'hA8, 16'h5A5A);
      host_u.wr(8'hAA, 16'h0400);
      host_u.wr(8'hAB, 16'h0800);
      host_u.wr(8'hA9, 16'h00F5);
      rdc(8'h28, 16'h5A5A);
      rdc(8'h2A, 16'h0400);
      rdc(8'h2B, 16'h0800);
      // exactly at the limit: the flag must stay low
      chk({15'h0, overflow}, 16'h0000);
      // with the clock enable low neither command nor write may land
      @(negedge clk) ce = 1'b0;
      host_u.wr(8'hA8, 16'hC3C3);
      ce = 1'b1;
      rdc(8'h28, 16'h5A5A);
      @(negedge clk) done_set = 3'b101;
      read_set = 3'b010;
      @(negedge clk) done_set = 3'b000;
      read_set = 3'b000;
      rdc(8'h2C, 16'h002A);
      // clears drop the flags, a set in the same cycle as a clear wins
      @(negedge clk) done_clr = 3'b111;
      read_clr = 3'b011;
      read_set = 3'b001;
      @(negedge clk) done_clr = 3'b000;
      read_clr = 3'b000;
      read_set = 3'b000;
      rdc(8'h2C, 16'h0001);
      host_u.cmd(8'h40);
      // the fourth access comes after the port has closed and must not count
      repeat (4) host_u.strobe();
      repeat (2) @(negedge clk);
      chk(eots, 16'h0001);
      @(negedge clk) transfer_byte_counter = 16'h0004;
      host_u.cmd(8'hC1);
      repeat (3) host_u.strobe();
      repeat (2) @(negedge clk);
      chk(eots, 16'h0002);
      host_u.wr(8'hA9, 16'h00F6);
      foreach (codes[i]) rdc(codes[i], 16'h0000);
      wrap_up();
   end
endmodule : uhr_regs_bench
